// [include/lcd_regs_pkg.sv]
// Constants shared by the LCD interface register bank and its palette store.
package lcd_regs_pkg;
   localparam int DATA_W = 8;
   localparam int INDEX_W = 4;
   localparam int REG_COUNT = 16;
   localparam int PSEL_W = 2;
   localparam int PENTRY_W = 4;
   localparam int PAL_ADDR_W = PSEL_W + PENTRY_W;
   localparam int PAL_LEVEL_W = 6;
   localparam int PAL_DEPTH = 64;

   localparam logic [3:0] IDX_CONTROL = 4'h0;
   localparam logic [3:0] IDX_INPUT_TIMING = 4'h1;
   localparam logic [3:0] IDX_HORIZONTAL_SIZE = 4'h2;
   localparam logic [3:0] IDX_VERTICAL_HIGH = 4'h3;
   localparam logic [3:0] IDX_VERTICAL_LOW = 4'h4;
   localparam logic [3:0] IDX_CENTER_RASTER = 4'h5;
   localparam logic [3:0] IDX_CENTER_CHAR = 4'h6;
   localparam logic [3:0] IDX_BORDER = 4'h7;
   localparam logic [3:0] IDX_STRETCH_CTRL = 4'h8;
   localparam logic [3:0] IDX_STRETCH_HIGH = 4'h9;
   localparam logic [3:0] IDX_STRETCH_LOW = 4'hA;
   localparam logic [3:0] IDX_PAL_ADDRESS = 4'hB;
   localparam logic [3:0] IDX_PAL_DATA = 4'hC;
   localparam logic [3:0] IDX_GRAD_HIGH = 4'hD;
   localparam logic [3:0] IDX_GRAD_LOW = 4'hE;
   localparam logic [3:0] IDX_RESERVED = 4'hF;

   // Writable bits per register; all other positions store nothing.
   localparam logic [7:0] REG_MASK [REG_COUNT] = '{
      8'h1F, 8'h1F, 8'h7F, 8'h01, 8'hFF, 8'hFF, 8'h1F, 8'h1F,
      8'h0F, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'h01, 8'hFF, 8'h00};

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] INDEX_RESET = 4'h0;
   localparam logic [5:0] LEVEL_RESET = 6'h00;

   localparam int STRETCH_EN_BIT = 4;
   localparam int CENTER_EN_BIT = 3;
   localparam int DOT_ADJ_EN_BIT = 4;
   localparam int BORDER_MODE_BIT = 4;
   localparam int BORDER_INT_BIT = 3;
endpackage

// [include/palette_if.sv]
// Connection between the register bank and its gradation palette store.
`timescale 1ns/1ps
`default_nettype none
interface palette_if;
   logic [5:0] host_addr;
   logic host_we;
   logic [5:0] host_wdata;
   logic [5:0] host_rdata;
   logic [5:0] look_addr;
   logic [5:0] look_level;
   modport store (input host_addr, input host_we, input host_wdata,
      output host_rdata, input look_addr, output look_level);
   modport ctrl (output host_addr, output host_we, output host_wdata,
      input host_rdata, output look_addr, input look_level);
endinterface
`default_nettype wire

// [src/lcd_register_bank.sv]
// Host-programmable register bank of the LCD interface controller.
//
// Behaviour
// [RULE1] Select low hits the index; select high hits the register it names.
// [RULE2] A deselected bank ignores writes and drives no read data; index reads give zero.
// [RULE3] Host writes zero into every invalid bit position.
// [RULE4] Invalid bit positions read back as zero, never stored content.
// [RULE5] Gradation period spans high and low registers; low holds bits 7..0.
// [RULE6] Vertical size low register holds bits 7..0; high holds bit 8.
// [RULE7] Palette address holds 2-bit palette select and 4-bit entry.
// [RULE8] Palette data reads and writes the 6-bit level at that address.
`timescale 1ns/1ps
`default_nettype none
module lcd_register_bank (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // Host bus
   input wire logic cs_b_i,
   input wire logic rd_b_i,
   input wire logic wr_b_i,
   input wire logic register_select_i,
   input wire logic [lcd_regs_pkg::DATA_W-1:0] data_i,
   output logic [lcd_regs_pkg::DATA_W-1:0] data_o,
   output logic data_oe_o,
   // Settings for the display blocks
   output logic stretch_enable_o,
   output logic centering_enable_o,
   output logic [2:0] control_low_o,
   output logic dot_adjust_enable_o,
   output logic [3:0] phase_adjust_field_o,
   output logic [6:0] horizontal_size_field_o,
   output logic [8:0] vertical_size_field_o,
   output logic [7:0] centering_raster_field_o,
   output logic [4:0] centering_char_field_o,
   output logic border_mode_o,
   output logic border_intensity_o,
   output logic [2:0] border_color_o,
   output logic [3:0] stretch_factor_field_o,
   output logic [15:0] stretch_index_field_o,
   output logic [8:0] gradation_period_field_o,
   // Palette lookup for the gradation logic
   input wire logic [lcd_regs_pkg::PAL_ADDR_W-1:0] lookup_addr_i,
   output logic [lcd_regs_pkg::PAL_LEVEL_W-1:0] lookup_level_o
);
   import lcd_regs_pkg::*;

   logic rst_s1_q;
   logic rst_n;
   logic cs_s1_q, cs_s2_q, cs_dl_q;
   logic rd_s1_q, rd_s2_q;
   logic wr_s1_q, wr_s2_q, wr_dl_q;
   logic rs_s1_q, rs_s2_q, rs_dl_q;
   logic [7:0] dat_s1_q, dat_s2_q, dat_dl_q;
   logic wr_evt;
   logic rd_act;
   logic [3:0] index_q, index_d;
   logic [7:0] regs_q [REG_COUNT];
   logic [7:0] regs_d [REG_COUNT];
   logic [7:0] data_q, data_d;
   logic oe_q, oe_d;
   logic [7:0] rd_mux;
   palette_if pal ();

   // Reset is released through two flops so every register leaves it together.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // Bus pins are asynchronous; a third stage gives the strobe edge.
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_dl_q <= 1'b1;
         rd_s1_q <= 1'b1;
         rd_s2_q <= 1'b1;
         wr_s1_q <= 1'b1;
         wr_s2_q <= 1'b1;
         wr_dl_q <= 1'b1;
         rs_s1_q <= 1'b0;
         rs_s2_q <= 1'b0;
         rs_dl_q <= 1'b0;
         dat_s1_q <= REG_RESET;
         dat_s2_q <= REG_RESET;
         dat_dl_q <= REG_RESET;
      end else begin
         cs_s1_q <= cs_b_i;
         cs_s2_q <= cs_s1_q;
         cs_dl_q <= cs_s2_q;
         rd_s1_q <= rd_b_i;
         rd_s2_q <= rd_s1_q;
         wr_s1_q <= wr_b_i;
         wr_s2_q <= wr_s1_q;
         wr_dl_q <= wr_s2_q;
         rs_s1_q <= register_select_i;
         rs_s2_q <= rs_s1_q;
         rs_dl_q <= rs_s2_q;
         dat_s1_q <= data_i;
         dat_s2_q <= dat_s1_q;
         dat_dl_q <= dat_s2_q;
      end
   end

   // A write commits on the trailing edge of the strobe, when data is settled.
   // [RULE2] Deselected bus ignored
   assign wr_evt = !cs_dl_q && !wr_dl_q && wr_s2_q;
   assign rd_act = !cs_s2_q && !rd_s2_q;

   // [RULE1] Index register write
   always_comb begin
      index_d = index_q;
      if (wr_evt && !rs_dl_q) begin
         index_d = dat_dl_q[INDEX_W-1:0];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         index_q <= INDEX_RESET;
      end else begin
         index_q <= index_d;
      end
   end

   // [RULE4] Masked indexed writes
   for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
      always_comb begin
         regs_d[g] = regs_q[g];
         if (wr_evt && rs_dl_q && index_q == 4'(g)) begin
            regs_d[g] = dat_dl_q & REG_MASK[g];
         end
      end

      always_ff @(posedge clock_i or negedge rst_n) begin
         if (!rst_n) begin
            regs_q[g] <= REG_RESET;
         end else begin
            regs_q[g] <= regs_d[g];
         end
      end
   end

   // [RULE7] Palette entry chosen by the address register
   assign pal.host_addr = regs_q[IDX_PAL_ADDRESS][PAL_ADDR_W-1:0];
   // [RULE8] Level written through the data register
   assign pal.host_we = wr_evt && rs_dl_q && index_q == IDX_PAL_DATA;
   assign pal.host_wdata = dat_dl_q[PAL_LEVEL_W-1:0];
   assign pal.look_addr = lookup_addr_i;

   palette_store u_palette (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .pal(pal.store)
   );

   // [RULE4] Read path returns zero in unreadable positions
   always_comb begin
      rd_mux = REG_RESET;
      if (!rs_s2_q) begin
         rd_mux = REG_RESET;
      end else if (index_q == IDX_PAL_ADDRESS || index_q == IDX_RESERVED) begin
         rd_mux = REG_RESET;
      end else if (index_q == IDX_PAL_DATA) begin
         rd_mux = {2'h0, pal.host_rdata};
      end else begin
         rd_mux = regs_q[index_q];
      end
      data_d = rd_act ? rd_mux : REG_RESET;
      oe_d = rd_act;
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= REG_RESET;
         oe_q <= 1'b0;
      end else begin
         data_q <= data_d;
         oe_q <= oe_d;
      end
   end

   assign data_o = data_q;
   assign data_oe_o = oe_q;
   assign stretch_enable_o = regs_q[IDX_CONTROL][STRETCH_EN_BIT];
   assign centering_enable_o = regs_q[IDX_CONTROL][CENTER_EN_BIT];
   assign control_low_o = regs_q[IDX_CONTROL][2:0];
   assign dot_adjust_enable_o = regs_q[IDX_INPUT_TIMING][DOT_ADJ_EN_BIT];
   assign phase_adjust_field_o = regs_q[IDX_INPUT_TIMING][3:0];
   assign horizontal_size_field_o = regs_q[IDX_HORIZONTAL_SIZE][6:0];
   // [RULE6] Vertical size split
   assign vertical_size_field_o = {regs_q[IDX_VERTICAL_HIGH][0],
      regs_q[IDX_VERTICAL_LOW]};
   assign centering_raster_field_o = regs_q[IDX_CENTER_RASTER];
   assign centering_char_field_o = regs_q[IDX_CENTER_CHAR][4:0];
   assign border_mode_o = regs_q[IDX_BORDER][BORDER_MODE_BIT];
   assign border_intensity_o = regs_q[IDX_BORDER][BORDER_INT_BIT];
   assign border_color_o = regs_q[IDX_BORDER][2:0];
   assign stretch_factor_field_o = regs_q[IDX_STRETCH_CTRL][3:0];
   assign stretch_index_field_o = {regs_q[IDX_STRETCH_HIGH],
      regs_q[IDX_STRETCH_LOW]};
   // [RULE5] Gradation period split
   assign gradation_period_field_o = {regs_q[IDX_GRAD_HIGH][0],
      regs_q[IDX_GRAD_LOW]};
   assign lookup_level_o = pal.look_level;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n);

   a_index_write: assert property ( // [RULE1]
      wr_evt && !rs_dl_q |=> {4'h0, index_q} == ($past(dat_dl_q) & 8'h0F))
      else $error("index not taken from host write");
   a_select_target: assert property ( // [RULE1]
      wr_evt && rs_dl_q && index_q == IDX_VERTICAL_LOW
      |=> regs_q[IDX_VERTICAL_LOW] == $past(dat_dl_q) && $stable(index_q))
      else $error("indexed write missed its register");
   a_deselect_quiet: assert property ( // [RULE2]
      cs_s2_q |=> !data_oe_o && data_o == 8'h00)
      else $error("deselected bank drove read data");
   a_index_unread: assert property ( // [RULE2]
      rd_act && !rs_s2_q |=> data_o == 8'h00 && data_oe_o)
      else $error("index register content visible on read");
   a_invalid_zero: assert property ( // [RULE4]
      rd_act && rs_s2_q && index_q == IDX_VERTICAL_HIGH
      |=> data_o[7:1] == 7'h00)
      else $error("invalid bits read nonzero");
   a_addr_unread: assert property ( // [RULE4]
      rd_act && rs_s2_q && index_q == IDX_PAL_ADDRESS |=> data_o == 8'h00)
      else $error("write-only palette address readable");
   a_grad_split: assert property ( // [RULE5]
      wr_evt && rs_dl_q && index_q == IDX_GRAD_LOW
      |=> gradation_period_field_o[7:0] == $past(dat_dl_q)
      && $stable(gradation_period_field_o[8]))
      else $error("gradation low byte not in bits 7..0");
   a_vert_split: assert property ( // [RULE6]
      wr_evt && rs_dl_q && index_q == IDX_VERTICAL_HIGH
      |=> {7'h00, vertical_size_field_o[8]} == ($past(dat_dl_q) & 8'h01)
      && $stable(vertical_size_field_o[7:0]))
      else $error("vertical high bit misplaced");
   a_pal_addr: assert property ( // [RULE7]
      wr_evt && rs_dl_q && index_q == IDX_PAL_ADDRESS
      |=> {2'h0, pal.host_addr} == ($past(dat_dl_q) & 8'h3F))
      else $error("palette address not taken");
   a_pal_data: assert property ( // [RULE8]
      pal.host_we |=> {2'h0, pal.host_rdata} == ($past(dat_dl_q) & 8'h3F))
      else $error("palette level not stored");

   c_index_write: cover property (wr_evt && !rs_dl_q);
   c_pal_write: cover property (pal.host_we);
   c_pal_read: cover property (rd_act && rs_s2_q && index_q == IDX_PAL_DATA);
   c_vert_read: cover property (rd_act && rs_s2_q && index_q == IDX_VERTICAL_LOW);
endmodule // lcd_register_bank
`default_nettype wire

// [src/palette_store.sv]
// Gradation level palettes: four palettes of sixteen six-bit levels.
`timescale 1ns/1ps
`default_nettype none
module palette_store (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Palette access
   palette_if.store pal
);
   import lcd_regs_pkg::*;

   logic [5:0] level_q [PAL_DEPTH];
   logic [5:0] level_d [PAL_DEPTH];
   logic [5:0] look_q;
   logic [5:0] look_d;

   always_comb begin
      level_d = level_q;
      if (pal.host_we) begin
         level_d[pal.host_addr] = pal.host_wdata;
      end
      look_d = level_q[pal.look_addr];
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < PAL_DEPTH; i++) begin
            level_q[i] <= LEVEL_RESET;
         end
         look_q <= LEVEL_RESET;
      end else begin
         level_q <= level_d;
         look_q <= look_d;
      end
   end

   assign pal.host_rdata = level_q[pal.host_addr];
   assign pal.look_level = look_q;
endmodule // palette_store
`default_nettype wire

// [verif/host_bus_model.sv]
// Host processor model driving the register bank's bus pins.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   // Clock
   input wire logic clock_i,
   // Bus pins
   output logic cs_b_o,
   output logic rd_b_o,
   output logic wr_b_o,
   output logic register_select_o,
   output logic [7:0] data_o,
   input wire logic [7:0] data_i,
   input wire logic data_oe_i
);
   initial begin
      cs_b_o = 1'b1;
      rd_b_o = 1'b1;
      wr_b_o = 1'b1;
      register_select_o = 1'b0;
      data_o = 8'h00;
   end

   task automatic bus_write(input logic sel, input logic [7:0] val,
         input logic chip);
      @(negedge clock_i);
      cs_b_o = ~chip;
      register_select_o = sel;
      data_o = val;
      wr_b_o = 1'b0;
      repeat (4) @(negedge clock_i);
      wr_b_o = 1'b1;
      repeat (4) @(negedge clock_i);
      cs_b_o = 1'b1;
      // A released bus shows the inverse so stale data is never mistaken.
      data_o = ~val;
      repeat (4) @(negedge clock_i);
   endtask

   task automatic bus_read(input logic sel, output logic [7:0] val,
         output logic oe);
      @(negedge clock_i);
      cs_b_o = 1'b0;
      register_select_o = sel;
      rd_b_o = 1'b0;
      repeat (5) @(negedge clock_i);
      val = data_i;
      oe = data_oe_i;
      rd_b_o = 1'b1;
      repeat (4) @(negedge clock_i);
      cs_b_o = 1'b1;
      repeat (4) @(negedge clock_i);
   endtask
endmodule // host_bus_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench for the LCD register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lcd_regs_pkg::*;
   typedef struct {logic [3:0] idx; logic [7:0] wd; logic [7:0] rd;} row_t;
   row_t rows [14] = '{'{4'h0, 8'h15, 8'h15}, '{4'h1, 8'h1F, 8'h1F},
      '{4'h2, 8'h7F, 8'h7F}, '{4'h3, 8'h01, 8'h01}, '{4'h4, 8'h5A, 8'h5A},
      '{4'h5, 8'hC3, 8'hC3}, '{4'h6, 8'h1F, 8'h1F}, '{4'h7, 8'h09, 8'h09},
      '{4'h8, 8'h0F, 8'h0F}, '{4'h9, 8'h12, 8'h12}, '{4'hA, 8'h34, 8'h34},
      '{4'hD, 8'h01, 8'h01}, '{4'hE, 8'h9C, 8'h9C}, '{4'hF, 8'h00, 8'h00}};
   logic clock_i, rst_b_i, cs_b, rd_b, wr_b, sel, oe, got_oe;
   logic [7:0] wdata, rdata, got;
   logic [2:0] ctl_low;
   logic [8:0] vsize, grad;
   logic [15:0] sidx;
   logic [5:0] lk_addr, lk_level;
   logic st_en, ce_en, dot_en, b_mode, b_int;
   logic [3:0] phase, sfac;
   logic [6:0] hsize;
   logic [7:0] craster;
   logic [4:0] cchar;
   logic [2:0] bcolor;
   int err_count = 0;
   int n_checks = 0;

   host_bus_model host (.clock_i(clock_i), .cs_b_o(cs_b), .rd_b_o(rd_b),
      .wr_b_o(wr_b), .register_select_o(sel), .data_o(wdata),
      .data_i(rdata), .data_oe_i(oe));

   lcd_register_bank DUT (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .cs_b_i(cs_b), .rd_b_i(rd_b), .wr_b_i(wr_b), .register_select_i(sel),
      .data_i(wdata), .data_o(rdata), .data_oe_o(oe),
      .stretch_enable_o(st_en), .centering_enable_o(ce_en),
      .control_low_o(ctl_low), .dot_adjust_enable_o(dot_en),
      .phase_adjust_field_o(phase), .horizontal_size_field_o(hsize),
      .vertical_size_field_o(vsize), .centering_raster_field_o(craster),
      .centering_char_field_o(cchar), .border_mode_o(b_mode),
      .border_intensity_o(b_int), .border_color_o(bcolor),
      .stretch_factor_field_o(sfac), .stretch_index_field_o(sidx),
      .gradation_period_field_o(grad), .lookup_addr_i(lk_addr),
      .lookup_level_o(lk_level));

   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   task automatic check(input string what, input logic [15:0] exp,
         input logic [15:0] seen);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [3:0] idx, input logic [7:0] val);
      host.bus_write(1'b0, {4'h0, idx}, 1'b1);
      host.bus_write(1'b1, val, 1'b1);
   endtask

   task automatic rd_reg(input logic [3:0] idx, output logic [7:0] val);
      logic o;
      host.bus_write(1'b0, {4'h0, idx}, 1'b1);
      host.bus_read(1'b1, val, o);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Watchdog: a hang counts as a mismatch.
   initial begin
      repeat (20000) @(posedge clock_i);
      err_count++;
      print_verdict();
   end

   initial begin
      rst_b_i = 1'b0;
      lk_addr = 6'h00;
      repeat (6) @(negedge clock_i);
      rst_b_i = 1'b1;
      repeat (6) @(negedge clock_i);
      check("oe_idle", 16'h0000, {15'h0000, oe});
      check("vsize_reset", 16'h0000, {7'h00, vsize});
      $display("test reset done");
      foreach (rows[i]) begin
         wr_reg(rows[i].idx, rows[i].wd);
         rd_reg(rows[i].idx, got);
         check("reg_read", {8'h00, rows[i].rd}, {8'h00, got});
      end
      $display("test register table done");
      check("vsize", 16'h015A, {7'h00, vsize});
      check("grad_period", 16'h019C, {7'h00, grad});
      check("stretch_index", 16'h1234, sidx);
      check("control_low", 16'h0005, {13'h0000, ctl_low});
      check("control_en", 16'h0002, {14'h0000, st_en, ce_en});
      check("input_timing", 16'h001F, {11'h000, dot_en, phase});
      check("hsize", 16'h007F, {9'h000, hsize});
      check("center_raster", 16'h00C3, {8'h00, craster});
      check("center_char", 16'h001F, {11'h000, cchar});
      check("border", 16'h0009, {11'h000, b_mode, b_int, bcolor});
      check("stretch_factor", 16'h000F, {12'h000, sfac});
      $display("test setting outputs done");
      host.bus_read(1'b0, got, got_oe);
      check("index_read", 16'h0000, {8'h00, got});
      check("index_oe", 16'h0001, {15'h0000, got_oe});
      host.bus_write(1'b0, 8'h04, 1'b1);
      host.bus_write(1'b1, 8'hEE, 1'b0);
      rd_reg(4'h4, got);
      check("unselected_write", 16'h005A, {8'h00, got});
      $display("test select done");
      wr_reg(4'hB, 8'h2B);
      wr_reg(4'hC, 8'h15);
      wr_reg(4'hB, 8'h05);
      wr_reg(4'hC, 8'h3F);
      wr_reg(4'hB, 8'h2B);
      rd_reg(4'hC, got);
      check("palette_level", 16'h0015, {8'h00, got});
      rd_reg(4'hB, got);
      check("palette_addr_read", 16'h0000, {8'h00, got});
      lk_addr = 6'h05;
      repeat (2) @(negedge clock_i);
      check("lookup_level", 16'h003F, {10'h000, lk_level});
      $display("test palette done");
      // A second reset in mid-run must clear settings and palettes alike.
      rst_b_i = 1'b0;
      repeat (6) @(negedge clock_i);
      rst_b_i = 1'b1;
      repeat (6) @(negedge clock_i);
      check("mid_reset_oe", 16'h0000, {15'h0000, oe});
      check("mid_reset_vsize", 16'h0000, {7'h00, vsize});
      check("mid_reset_grad", 16'h0000, {7'h00, grad});
      check("mid_reset_sidx", 16'h0000, sidx);
      check("mid_reset_level", 16'h0000, {10'h000, lk_level});
      rd_reg(4'h4, got);
      check("mid_reset_read", 16'h0000, {8'h00, got});
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule // tb
`default_nettype wire
